// ---- src/ussm_core.v ----
// Purpose: Synchronous master mode of a serial transceiver with APB registers
// Assumes: 40 MHz clk, one shift clock period = 2*(baud_divisor+1) clk cycles
// Notes: Data line pin is split in/out/enable, enable low while driving
// Notes on behaviour
// - half duplex: transmit and receive exclusive
// - sync select bit selects synchronous operation
// - port enable assigns clock and data pins
// - clock source bit makes device drive clock
// - shifter reloads only after last bit
// - one-cycle load then buffer-empty flag set
// - empty flag set regardless of its enable
// - flag cleared only by buffer write
// - shifter-empty status read-only, polled only
// - shift register not software accessible
// - ninth transmit bit from ninth-bit field
// - single or continuous enable starts reception
// - sample data on falling shift clock
// - single enable receives exactly one word
// - continuous enable receives until cleared
// - both set behaves as continuous
// - receive-complete flag, interrupt only if enabled
// - clearing continuous enable clears errors
// - ninth receive bit readable in control
`timescale 1ns/10ps
`include "ussm_defs.vh"

module ussm_core #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Serial pins
  output reg shiftClockLine,
  output reg shiftClockOe_n,
  input wire serialDataIn,
  output reg serialDataOut,
  output reg serialDataOe_n,
  // Interrupt request lines
  output reg txIrq,
  output reg rxIrq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_TX = 2'b01;
  localparam ST_RX = 2'b10;

  // ==========================================================
  // Registers
  reg [7:0] txCtrl_r;
  reg [7:0] rxCtrl_r;
  reg [7:0] txHold_r;
  reg [7:0] rxBuf_r;
  reg [7:0] irqEn_r;
  reg [7:0] baud_r;
  reg txEmptyFlag_r;
  reg rxDoneFlag_r;
  reg holdFull_r;
  reg [1:0] state_r;
  reg [8:0] shifter_r;
  reg [3:0] bitCnt_r;
  reg [7:0] divCnt_r;
  reg phaseHigh_r;
  reg dataSync1_r;
  reg dataSync2_r;

  // ==========================================================
  // Address decode
  function [3:0] decodeIdx;
    input [ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'b00 || a[ADDR_W-1:10] != 0) begin
        decodeIdx = 4'h0;
      end else if (a[9:2] == `USSM_IDX_IRQ_FLAGS) begin
        decodeIdx = 4'h1;
      end else if (a[9:2] == `USSM_IDX_RX_CTRL) begin
        decodeIdx = 4'h2;
      end else if (a[9:2] == `USSM_IDX_TX_HOLD) begin
        decodeIdx = 4'h3;
      end else if (a[9:2] == `USSM_IDX_RX_BUF) begin
        decodeIdx = 4'h4;
      end else if (a[9:2] == `USSM_IDX_IRQ_EN) begin
        decodeIdx = 4'h5;
      end else if (a[9:2] == `USSM_IDX_TX_CTRL) begin
        decodeIdx = 4'h6;
      end else if (a[9:2] == `USSM_IDX_BAUD) begin
        decodeIdx = 4'h7;
      end else begin
        decodeIdx = 4'h0;
      end
    end
  endfunction

  wire [3:0] regSel = decodeIdx(paddr);
  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire rdEn = access && !pwrite;
  assign pready = 1'b1;
  // Shift register has no index, so it falls to the error slot
  assign pslverr = access && (regSel == 4'h0);

  // ==========================================================
  // Mode and control decode
  wire syncMode = txCtrl_r[`USSM_TX_SYNC];
  wire portOn = rxCtrl_r[`USSM_RX_PORTEN];
  wire isMaster = txCtrl_r[`USSM_TX_CLKSRC];
  wire active = syncMode && portOn && isMaster;
  wire contRx = rxCtrl_r[`USSM_RX_CONT];
  wire rxWanted = rxCtrl_r[`USSM_RX_SINGLE] || contRx;
  wire nineTx = txCtrl_r[`USSM_TX_NINE];
  wire nineRx = rxCtrl_r[`USSM_RX_NINE];
  wire holdWrite = wrEn && (regSel == 4'h3);

  // ==========================================================
  // Shift clock divider
  wire divDone = (divCnt_r == 8'h00);
  wire riseTick = divDone && !phaseHigh_r && (state_r != ST_IDLE);
  wire fallTick = divDone && phaseHigh_r;
  wire [3:0] wordBits = nineTx ? 4'h9 : 4'h8;
  wire [3:0] rxBits = nineRx ? 4'h9 : 4'h8;

  always @(posedge clk) begin
    if (sys_rst || state_r == ST_IDLE) begin
      divCnt_r <= baud_r;
      phaseHigh_r <= 1'b0;
    end else if (divDone) begin
      divCnt_r <= baud_r;
      phaseHigh_r <= !phaseHigh_r;
    end else begin
      divCnt_r <= divCnt_r - 8'h01;
    end
  end

  // Data line synchroniser
  always @(posedge clk) begin
    if (sys_rst) begin
      dataSync1_r <= 1'b0;
      dataSync2_r <= 1'b0;
    end else begin
      dataSync1_r <= serialDataIn;
      dataSync2_r <= dataSync1_r;
    end
  end

  // ==========================================================
  // Transfer engine
  always @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      shifter_r <= 9'h000;
      bitCnt_r <= 4'h0;
      holdFull_r <= 1'b0;
      txEmptyFlag_r <= 1'b0;
      rxDoneFlag_r <= 1'b0;
      rxBuf_r <= `USSM_RST_ZERO;
    end else begin
      if (rdEn && regSel == 4'h4) begin
        rxDoneFlag_r <= 1'b0;
      end
      if (!txCtrl_r[`USSM_TX_EN]) begin
        holdFull_r <= 1'b0;
      end else if (holdWrite) begin
        holdFull_r <= 1'b1;
      end
      if (holdWrite) begin
        txEmptyFlag_r <= 1'b0;
      end else if (txCtrl_r[`USSM_TX_EN] && !holdFull_r) begin
        txEmptyFlag_r <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          if (active && txCtrl_r[`USSM_TX_EN] && holdFull_r && !rxWanted) begin
            shifter_r <= {txCtrl_r[`USSM_TX_BIT9], txHold_r};
            bitCnt_r <= 4'h0;
            holdFull_r <= holdWrite;
            // A write landing in the load cycle refills the buffer at once
            txEmptyFlag_r <= !holdWrite;
            state_r <= ST_TX;
          end else if (active && rxWanted) begin
            bitCnt_r <= 4'h0;
            state_r <= ST_RX;
          end
        end
        ST_TX: begin
          if (fallTick) begin
            shifter_r <= {1'b0, shifter_r[8:1]};
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == wordBits - 4'h1) begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RX: begin
          if (fallTick) begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (nineRx) begin
              shifter_r <= {dataSync2_r, shifter_r[8:1]};
            end else begin
              shifter_r <= {1'b0, dataSync2_r, shifter_r[7:1]};
            end
            if (bitCnt_r == rxBits - 4'h1) begin
              rxDoneFlag_r <= 1'b1;
              // In eight-bit mode the last data bit joins the word in the same cycle; in nine-bit mode it goes to the ninth-bit field
              rxBuf_r <= nineRx ? shifter_r[8:1] : {dataSync2_r, shifter_r[7:1]};
              state_r <= ST_IDLE;
            end
          end
          if (!rxWanted || !active) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Word landed this cycle, for ninth bit and single-mode stop
  wire rxLast = (state_r == ST_RX) && fallTick && (bitCnt_r == rxBits - 4'h1);

  // ==========================================================
  // Software registers
  always @(posedge clk) begin
    if (sys_rst) begin
      txCtrl_r <= `USSM_RST_TX_CTRL;
      rxCtrl_r <= `USSM_RST_ZERO;
      txHold_r <= `USSM_RST_ZERO;
      irqEn_r <= `USSM_RST_ZERO;
      baud_r <= `USSM_RST_ZERO;
    end else begin
      if (wrEn && regSel == 4'h6) begin
        txCtrl_r <= {pwdata[7:2], txCtrl_r[`USSM_TX_SHEMPTY], pwdata[0]};
        txCtrl_r[3] <= 1'b0;
      end
      txCtrl_r[`USSM_TX_SHEMPTY] <= (state_r != ST_TX);
      if (holdWrite) begin
        txHold_r <= pwdata[7:0];
      end
      if (wrEn && regSel == 4'h5) begin
        irqEn_r <= pwdata[7:0];
      end
      if (wrEn && regSel == 4'h7) begin
        baud_r <= pwdata[7:0];
      end
      if (wrEn && regSel == 4'h2) begin
        rxCtrl_r[7:3] <= pwdata[7:3];
      end
      if (rxLast) begin
        if (nineRx) begin
          rxCtrl_r[`USSM_RX_BIT9] <= dataSync2_r;
        end
        if (!contRx) begin
          rxCtrl_r[`USSM_RX_SINGLE] <= 1'b0;
        end
      end
      if (rxLast && rxDoneFlag_r && contRx) begin
        rxCtrl_r[`USSM_RX_OVER] <= 1'b1;
      end else if (!contRx) begin
        rxCtrl_r[`USSM_RX_OVER] <= 1'b0;
      end
      rxCtrl_r[`USSM_RX_FRAME] <= 1'b0;
    end
  end

  // ==========================================================
  // Pins and read data
  always @(posedge clk) begin
    if (sys_rst) begin
      shiftClockLine <= 1'b0;
      shiftClockOe_n <= 1'b1;
      serialDataOut <= 1'b0;
      serialDataOe_n <= 1'b1;
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
    end else begin
      shiftClockOe_n <= !active;
      shiftClockLine <= (state_r != ST_IDLE) && (phaseHigh_r ^ riseTick ^ fallTick);
      serialDataOe_n <= !(portOn && syncMode && state_r == ST_TX);
      serialDataOut <= shifter_r[0];
      txIrq <= txEmptyFlag_r && irqEn_r[`USSM_IRQ_TXEMPTY];
      rxIrq <= rxDoneFlag_r && irqEn_r[`USSM_IRQ_RXDONE];
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    if (regSel == 4'h1) begin
      prdata[`USSM_IRQ_RXDONE] = rxDoneFlag_r;
      prdata[`USSM_IRQ_TXEMPTY] = txEmptyFlag_r;
    end else if (regSel == 4'h2) begin
      prdata[7:0] = rxCtrl_r;
    end else if (regSel == 4'h3) begin
      prdata[7:0] = txHold_r;
    end else if (regSel == 4'h4) begin
      prdata[7:0] = rxBuf_r;
    end else if (regSel == 4'h5) begin
      prdata[7:0] = irqEn_r;
    end else if (regSel == 4'h6) begin
      prdata[7:0] = txCtrl_r;
    end else if (regSel == 4'h7) begin
      prdata[7:0] = baud_r;
    end
  end

endmodule

// ---- pkg/ussm_defs.vh ----
// Purpose: Offsets, field positions and reset values of the sync master port
// Assumes: 32-bit APB word per register
// Notes: Printed offsets are not all multiples of four; byte address is 4x index
`ifndef USSM_DEFS_VH
`define USSM_DEFS_VH

// ==========================================================
// Register indices
`define USSM_IDX_IRQ_FLAGS 8'h0c
`define USSM_IDX_RX_CTRL 8'h18
`define USSM_IDX_TX_HOLD 8'h19
`define USSM_IDX_RX_BUF 8'h1a
`define USSM_IDX_IRQ_EN 8'h8c
`define USSM_IDX_TX_CTRL 8'h98
`define USSM_IDX_BAUD 8'h99

// ==========================================================
// Transmit control fields
`define USSM_TX_CLKSRC 7
`define USSM_TX_NINE 6
`define USSM_TX_EN 5
`define USSM_TX_SYNC 4
`define USSM_TX_HIRATE 2
`define USSM_TX_SHEMPTY 1
`define USSM_TX_BIT9 0

// ==========================================================
// Receive control fields
`define USSM_RX_PORTEN 7
`define USSM_RX_NINE 6
`define USSM_RX_SINGLE 5
`define USSM_RX_CONT 4
`define USSM_RX_ADDR 3
`define USSM_RX_FRAME 2
`define USSM_RX_OVER 1
`define USSM_RX_BIT9 0

// ==========================================================
// Flag and enable fields
`define USSM_IRQ_RXDONE 5
`define USSM_IRQ_TXEMPTY 4

// ==========================================================
// Reset values
`define USSM_RST_TX_CTRL 8'h02
`define USSM_RST_ZERO 8'h00

`endif

// ---- bench/ussm_core_properties.sv ----
// Purpose: Port assertions of the sync master port
// Assumes: Shadow copies of the written control registers
// Notes: Bound into ussm_core
`timescale 1ns/10ps
module ussm_core_props #(parameter ADDR_W = 12) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // Serial pins and requests
  input wire shiftClockLine,
  input wire shiftClockOe_n,
  input wire serialDataIn,
  input wire serialDataOut,
  input wire serialDataOe_n,
  input wire txIrq,
  input wire rxIrq
);
  // ==========
  // Shadow registers
  reg [7:0] baud_r, ie_r, ieD_r, tx_r, rc_r;
  reg [8:0] hiCnt_r;
  reg okD_r;
  wire wr = psel && penable && pwrite;
  wire ok = tx_r[7] && tx_r[4] && rc_r[7];
  wire mapped = paddr inside {12'h030, 12'h060, 12'h064, 12'h068, 12'h230, 12'h260, 12'h264};
  always @(posedge clk) begin
    hiCnt_r <= shiftClockLine ? hiCnt_r + 9'h001 : 9'h000;
    ieD_r <= ie_r;
    okD_r <= ok;
    if (sys_rst) begin
      baud_r <= 8'h00;
      ie_r <= 8'h00;
      tx_r <= 8'h00;
      rc_r <= 8'h00;
    end else if (wr) begin
      if (paddr == 12'h264) baud_r <= pwdata[7:0];
      if (paddr == 12'h230) ie_r <= pwdata[7:0];
      if (paddr == 12'h260) tx_r <= pwdata[7:0];
      if (paddr == 12'h060) rc_r <= pwdata[7:0];
    end
  end
  // ==========
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence badAccess;
    psel && !penable && !mapped ##1 psel && penable;
  endsequence
  clk_owner_a:
    assert property ($changed(shiftClockLine) |-> !shiftClockOe_n) else $error("clock moved");
  pins_off_a:
    assert property (!ok && !okD_r |-> shiftClockOe_n && serialDataOe_n) else $error("pins on");
  data_hold_a:
    assert property ($changed(serialDataOut) |-> !shiftClockLine) else $error("data moved");
  half_period_a:
    assert property ($fell(shiftClockLine) |-> hiCnt_r == {1'b0, baud_r} + 9'h001)
      else $error("bad half period");
  tx_drive_a:
    assert property (!serialDataOe_n |-> okD_r) else $error("data driven unconfigured");
  unmapped_a:
    assert property (badAccess |-> pslverr && prdata == 32'h0) else $error("unmapped access");
  tx_irq_a:
    assert property (!ie_r[4] && !ieD_r[4] |-> !txIrq) else $error("tx request ungated");
  rx_irq_a:
    assert property (!ie_r[5] && !ieD_r[5] |-> !rxIrq) else $error("rx request ungated");
endmodule

bind ussm_core ussm_core_props #(.ADDR_W(ADDR_W)) props (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .shiftClockLine(shiftClockLine),
  .shiftClockOe_n(shiftClockOe_n), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
  .serialDataOe_n(serialDataOe_n), .txIrq(txIrq), .rxIrq(rxIrq));

// ---- bench/ussm_slave_model.sv ----
// Purpose: External synchronous slave on the clock and data lines
// Assumes: Shift clock idle low, seen through clk
// Notes: Repeats its word lsb first, captures sent bits
`timescale 1ns/10ps
module ussm_slave_model (
  // Clock
  input wire clk,
  // Line side
  input wire shiftClockLine,
  input wire serialDataOut,
  input wire serialDataOe_n,
  output wire serialDataIn,
  // Bench side
  input wire [8:0] sendWord,
  input wire nine,
  input wire load,
  output reg [8:0] gotWord
);
  // ==========
  // Shifters
  reg clkPrev_r = 1'b0;
  reg drive_r = 1'b1;
  reg [3:0] idx_r = 4'h0;
  // Device wins the wire while its enable is low
  assign serialDataIn = serialDataOe_n ? drive_r : serialDataOut;
  always @(posedge clk) begin
    clkPrev_r <= shiftClockLine;
    if (load) begin
      idx_r <= 4'h0;
    end else if (shiftClockLine && !clkPrev_r) begin
      drive_r <= sendWord[idx_r];
      idx_r <= (idx_r == (nine ? 4'h8 : 4'h7)) ? 4'h0 : idx_r + 4'h1;
      if (!serialDataOe_n) gotWord <= {serialDataOut, gotWord[8:1]};
    end
  end
endmodule

// ---- bench/usart_sync_master_mode_tb.sv ----
// Purpose: Self-checking bench of the sync master port
// Assumes: 40 MHz clk, baud divisor 3
// Notes: Slave model on the serial lines
`timescale 1ns/10ps
`include "ussm_defs.vh"
module usart_sync_master_mode_tb;
  // ==========
  // Signals
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [8:0] sendWord = 9'h000;
  reg nine = 1'b0;
  reg load = 1'b0;
  reg [31:0] rd;
  reg err;
  wire pready, pslverr, sck, sckOe_n, dIn, dOut, dOe_n, txIrq, rxIrq;
  wire [31:0] prdata;
  wire [8:0] gotWord;
  integer n_fail = 0;
  integer total_checks = 0;
  ussm_core #(.ADDR_W(12)) dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .shiftClockLine(sck), .shiftClockOe_n(sckOe_n), .serialDataIn(dIn),
    .serialDataOut(dOut), .serialDataOe_n(dOe_n), .txIrq(txIrq), .rxIrq(rxIrq));
  ussm_slave_model slave (.clk(clk), .shiftClockLine(sck), .serialDataOut(dOut),
    .serialDataOe_n(dOe_n), .serialDataIn(dIn), .sendWord(sendWord), .nine(nine),
    .load(load), .gotWord(gotWord));
  // ==========
  // Shared tasks
  task apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, ix, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input logic [7:0] ix, input logic [7:0] m, input logic [7:0] e);
    begin
      apb(1'b0, ix, 8'h00);
      chk(rd & {24'h0, m}, {24'h0, e});
    end
  endtask
  task waitbit(input logic [7:0] ix, input integer b, input logic v);
    integer k;
    begin
      k = 0;
      apb(1'b0, ix, 8'h00);
      while (rd[b] !== v && k < 300) begin
        apb(1'b0, ix, 8'h00);
        k = k + 1;
      end
      chk({31'h0, rd[b]}, {31'h0, v});
    end
  endtask
  task reload(input logic [8:0] w, input logic n);
    begin
      @(posedge clk);
      sendWord <= w;
      nine <= n;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
    end
  endtask
  // ==========
  // Scenarios
  task t_reset;
    begin
      rdchk(`USSM_IDX_TX_CTRL, 8'hff, 8'h02);
      rdchk(`USSM_IDX_IRQ_FLAGS, 8'hff, 8'h00);
      apb(1'b1, `USSM_IDX_TX_CTRL, 8'h00);
      rdchk(`USSM_IDX_TX_CTRL, 8'hff, 8'h02);
      apb(1'b1, 8'h01, 8'h55);
      chk({31'h0, err}, 32'h1);
      $display("reset test done");
    end
  endtask
  task t_tx;
    begin
      apb(1'b1, `USSM_IDX_BAUD, 8'h03);
      apb(1'b1, `USSM_IDX_RX_CTRL, 8'h80);
      apb(1'b1, `USSM_IDX_TX_CTRL, 8'hb0);
      rdchk(`USSM_IDX_IRQ_FLAGS, 8'h10, 8'h10);
      apb(1'b1, `USSM_IDX_IRQ_FLAGS, 8'h00);
      rdchk(`USSM_IDX_IRQ_FLAGS, 8'h10, 8'h10);
      apb(1'b1, `USSM_IDX_TX_HOLD, 8'ha5);
      apb(1'b1, `USSM_IDX_TX_HOLD, 8'h3c);
      rdchk(`USSM_IDX_IRQ_FLAGS, 8'h10, 8'h00);
      rdchk(`USSM_IDX_TX_CTRL, 8'h02, 8'h00);
      apb(1'b1, `USSM_IDX_IRQ_EN, 8'h10);
      waitbit(`USSM_IDX_IRQ_FLAGS, 4, 1'b1);
      @(negedge clk);
      chk({31'h0, txIrq}, 32'h1);
      waitbit(`USSM_IDX_TX_CTRL, 1, 1'b1);
      chk({23'h0, gotWord}, 32'h079);
      apb(1'b1, `USSM_IDX_IRQ_EN, 8'h00);
      $display("transmit test done");
    end
  endtask
  task t_nine;
    begin
      apb(1'b1, `USSM_IDX_TX_CTRL, 8'hf1);
      apb(1'b1, `USSM_IDX_TX_HOLD, 8'h5a);
      waitbit(`USSM_IDX_TX_CTRL, 1, 1'b1);
      chk({23'h0, gotWord}, 32'h15a);
      apb(1'b1, `USSM_IDX_TX_CTRL, 8'h90);
      $display("nine bit transmit test done");
    end
  endtask
  task t_rx_single;
    begin
      reload(9'h0c3, 1'b0);
      apb(1'b1, `USSM_IDX_IRQ_EN, 8'h20);
      apb(1'b1, `USSM_IDX_RX_CTRL, 8'ha0);
      waitbit(`USSM_IDX_IRQ_FLAGS, 5, 1'b1);
      @(negedge clk);
      chk({31'h0, rxIrq}, 32'h1);
      rdchk(`USSM_IDX_RX_CTRL, 8'hfe, 8'h80);
      rdchk(`USSM_IDX_RX_BUF, 8'hff, 8'hc3);
      $display("single receive test done");
    end
  endtask
  task t_rx_cont;
    begin
      reload(9'h1a5, 1'b1);
      apb(1'b1, `USSM_IDX_RX_CTRL, 8'hf0);
      waitbit(`USSM_IDX_IRQ_FLAGS, 5, 1'b1);
      rdchk(`USSM_IDX_RX_CTRL, 8'h11, 8'h11);
      rdchk(`USSM_IDX_RX_BUF, 8'hff, 8'ha5);
      waitbit(`USSM_IDX_IRQ_FLAGS, 5, 1'b1);
      rdchk(`USSM_IDX_RX_BUF, 8'hff, 8'ha5);
      apb(1'b1, `USSM_IDX_RX_CTRL, 8'h80);
      rdchk(`USSM_IDX_RX_CTRL, 8'h16, 8'h00);
      $display("continuous receive test done");
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ==========
  // Clock, sequence, watchdog
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_tx;
    t_nine;
    t_rx_single;
    t_rx_cont;
    end_of_test;
  end
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    end_of_test;
  end
endmodule
